/* File: emt_bus.v */
// Purpose: External memory bus sequencer with APB registers
// Assumes: One clock at 125 MHz, async active-low reset, external move
//          requests come from core logic on the same clock
// Notes:   One access at a time; busy stays high until the last clock
//
// The implementer's own choices: the address map and the APB register port.
`include "emt_regs.vh"
module emt_bus (
   input  wire        clk,
   input  wire        resetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Move request from core
   input  wire        req,
   input  wire        req_write,
   input  wire        req_wide,
   input  wire [15:0] req_addr,
   input  wire [7:0]  req_wdata,
   input  wire        upper_group,
   output reg         busy,
   output reg         done,
   output reg  [7:0]  rdata,
   // External bus pins
   output reg  [15:0] addr_out,
   output reg  [15:0] addr_oe,
   output reg  [7:0]  data_out,
   output reg         data_oe,
   input  wire [7:0]  data_in,
   output reg         ale,
   output reg         rd_n,
   output reg         wr_n,
   output reg         low_group_en,
   output reg         high_group_en
);
   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_ALEH  = 3'd1;
   localparam [2:0] ST_ALEL  = 3'd2;
   localparam [2:0] ST_SETUP = 3'd3;
   localparam [2:0] ST_STRB  = 3'd4;
   localparam [2:0] ST_HOLD  = 3'd5;
   localparam [2:0] ST_TAIL  = 3'd6;

   reg  [4:0]  ext_mem_config_field;
   reg  [7:0]  ext_mem_timing_ctrl;
   reg  [7:0]  ext_mem_bank_page;
   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg         cnt_load;
   reg  [4:0]  cnt_value;
   wire        cnt_done;
   reg         op_write;
   reg         op_wide;
   reg  [15:0] op_addr;
   reg  [7:0]  op_wdata;
   reg         op_upper;
   reg  [7:0]  din_s1;
   reg  [7:0]  din_s2;

   wire [2:0]  mode      = ext_mem_config_field[`EMT_MODE_HI:`EMT_MODE_LO];
   wire [1:0]  ale_sel   = ext_mem_config_field[`EMT_ALE_HI:`EMT_ALE_LO];
   wire [1:0]  setup_sel = ext_mem_timing_ctrl[`EMT_SETUP_HI:`EMT_SETUP_LO];
   wire [3:0]  width_sel = ext_mem_timing_ctrl[`EMT_WIDTH_HI:`EMT_WIDTH_LO];
   wire [1:0]  hold_sel  = ext_mem_timing_ctrl[`EMT_HOLD_HI:`EMT_HOLD_LO];
   // Mode decode: bit 4 set means separate address and data lines, except mode 100, which turns the bus off
   wire        non_mux   = (mode == 3'b101) || (mode == 3'b110) || (mode == 3'b111);
   wire        mux       = (mode == 3'b001) || (mode == 3'b010) || (mode == 3'b011);
   wire        bank_mode = (mode == 3'b110) || (mode == 3'b010);
   wire        bus_on    = non_mux || mux;
   wire        apb_acc   = psel && penable;
   wire        apb_wr    = apb_acc && pwrite && pready;

   // Register writes; timing register resets to all ones
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ext_mem_config_field <= `EMT_CONFIG_RST;
         ext_mem_timing_ctrl  <= `EMT_TIMING_RST;
         ext_mem_bank_page    <= `EMT_BANK_RST;
      end else if (apb_wr) begin
         case (paddr)
            `EMT_OFF_CONFIG: ext_mem_config_field <= pwdata[4:0];
            `EMT_OFF_TIMING: ext_mem_timing_ctrl  <= pwdata[7:0];
            `EMT_OFF_BANK:   ext_mem_bank_page    <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Zero-wait APB answer; unmapped addresses report an error
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               `EMT_OFF_CONFIG: prdata <= {27'h0, ext_mem_config_field};
               `EMT_OFF_TIMING: prdata <= {24'h0, ext_mem_timing_ctrl};
               `EMT_OFF_BANK:   prdata <= {24'h0, ext_mem_bank_page};
               `EMT_OFF_STATUS: prdata <= {29'h0, state};
               `EMT_OFF_RDATA:  prdata <= {24'h0, rdata};
               default:         pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Pin data passes two flip-flops before use
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         din_s1 <= 8'h00;
         din_s2 <= 8'h00;
      end else begin
         din_s1 <= data_in;
         din_s2 <= din_s1;
      end
   end

   // Phase sequencing; each phase reloads the shared down counter
   always @* begin
      next_state = state;
      cnt_load   = 1'b0;
      cnt_value  = 5'h00;
      case (state)
         ST_IDLE: begin
            if (req && bus_on) begin
               cnt_load = 1'b1;
               if (mux) begin
                  next_state = ST_ALEH;
                  cnt_value  = {3'b000, ale_sel};
               end else begin
                  next_state = ST_SETUP;
                  cnt_value  = {3'b000, setup_sel};
               end
            end
         end
         ST_ALEH: begin
            if (cnt_done) begin
               next_state = ST_ALEL;
               cnt_load   = 1'b1;
               cnt_value  = {3'b000, ale_sel};
            end
         end
         ST_ALEL: begin
            if (cnt_done) begin
               next_state = ST_SETUP;
               cnt_load   = 1'b1;
               cnt_value  = {3'b000, setup_sel};
            end
         end
         ST_SETUP: begin
            if (cnt_done) begin
               next_state = ST_STRB;
               cnt_load   = 1'b1;
               cnt_value  = {1'b0, width_sel};
            end
         end
         ST_STRB: begin
            if (cnt_done) begin
               next_state = ST_HOLD;
               cnt_load   = 1'b1;
               cnt_value  = {3'b000, hold_sel};
            end
         end
         ST_HOLD: begin
            if (cnt_done) begin
               // Overhead clocks pad the access out to its full length
               next_state = ST_TAIL;
               cnt_load   = 1'b1;
               cnt_value  = {2'b00, `EMT_OVERHEAD} - 5'd4;
            end
         end
         ST_TAIL: begin
            if (cnt_done) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   emt_counter u_cnt (
      .clk    (clk),
      .resetn (resetn),
      .load   (cnt_load),
      .value  (cnt_value),
      .done   (cnt_done)
   );

   // Setup phase of zero is still one clock of address before the strobe
   // a setting of n gives n+1 clocks; overhead absorbs the extra one

   // Latch request and drive pins from registered state
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state         <= ST_IDLE;
         op_write      <= 1'b0;
         op_wide       <= 1'b0;
         op_addr       <= 16'h0000;
         op_wdata      <= 8'h00;
         op_upper      <= 1'b0;
         busy          <= 1'b0;
         done          <= 1'b0;
         rdata         <= 8'h00;
         addr_out      <= 16'h0000;
         addr_oe       <= 16'h0000;
         data_out      <= 8'h00;
         data_oe       <= 1'b0;
         ale           <= 1'b0;
         rd_n          <= 1'b1;
         wr_n          <= 1'b1;
         low_group_en  <= 1'b0;
         high_group_en <= 1'b0;
      end else begin
         state <= next_state;
         done  <= 1'b0;
         if (state == ST_IDLE && req && bus_on) begin
            op_write <= req_write;
            op_wide  <= req_wide;
            op_upper <= upper_group;
            op_wdata <= req_wdata;
            // Bank page supplies high byte of 8-bit moves in bank modes
            if (!req_wide && bank_mode)
               op_addr <= {ext_mem_bank_page, req_addr[7:0]};
            else
               op_addr <= req_addr;
         end
         busy          <= (next_state != ST_IDLE);
         // Pins live only while a move is in progress
         low_group_en  <= (next_state != ST_IDLE) && !op_sel_upper(state, op_upper, upper_group);
         high_group_en <= (next_state != ST_IDLE) && op_sel_upper(state, op_upper, upper_group);
         ale           <= (next_state == ST_ALEH);
         rd_n          <= !((next_state == ST_STRB) && !cur_write(state, op_write, req_write));
         wr_n          <= !((next_state == ST_STRB) && cur_write(state, op_write, req_write));
         // Address bus: 8-bit plain moves leave the high byte undriven
         if (next_state != ST_IDLE && next_state != ST_TAIL) begin
            addr_out <= cur_addr(state);
            addr_oe  <= (cur_wide(state) || bank_mode) ? 16'hFFFF : 16'h00FF;
         end else begin
            addr_oe  <= 16'h0000;
         end
         // Multiplexed: low byte carries address during latch phases
         if (mux && (next_state == ST_ALEH || next_state == ST_ALEL)) begin
            data_out <= low_byte(cur_addr(state));
            data_oe  <= 1'b1;
         end else if (cur_write(state, op_write, req_write) &&
                      (next_state == ST_SETUP || next_state == ST_STRB ||
                       next_state == ST_HOLD)) begin
            data_out <= (state == ST_IDLE) ? req_wdata : op_wdata;
            data_oe  <= 1'b1;
         end else begin
            data_oe  <= 1'b0;
         end
         // Read data taken on the last strobe clock; the synchroniser makes the
         // sample two clocks old, so reads need a strobe of three clocks or more
         if (state == ST_STRB && cnt_done && !op_write) begin
            rdata <= din_s2;
         end
         if (state == ST_TAIL && cnt_done) begin
            done <= 1'b1;
         end
      end
   end

   // Request values are used in the launch clock, stored ones afterwards
   function op_sel_upper;
      input [2:0] st;
      input       stored;
      input       live;
      begin
         op_sel_upper = (st == ST_IDLE) ? live : stored;
      end
   endfunction

   function cur_write;
      input [2:0] st;
      input       stored;
      input       live;
      begin
         cur_write = (st == ST_IDLE) ? live : stored;
      end
   endfunction

   function cur_wide;
      input [2:0] st;
      begin
         cur_wide = (st == ST_IDLE) ? req_wide : op_wide;
      end
   endfunction

   function [15:0] cur_addr;
      input [2:0] st;
      begin
         if (st != ST_IDLE)
            cur_addr = op_addr;
         else if (!req_wide && bank_mode)
            cur_addr = {ext_mem_bank_page, req_addr[7:0]};
         else
            cur_addr = req_addr;
      end
   endfunction

   // Low byte of an address for the shared lines in latch phases
   function [7:0] low_byte;
      input [15:0] word;
      begin
         low_byte = word[7:0];
      end
   endfunction
endmodule

/* File: emt_regs.vh */
// Purpose: Constants for the external memory bus timing block
// Assumes: APB register map, one aligned 32-bit word per register
// Notes:   Timing fields count whole system clock periods
`ifndef EMT_REGS_VH
`define EMT_REGS_VH
// Register byte offsets
`define EMT_OFF_CONFIG     12'h000
`define EMT_OFF_TIMING     12'h004
`define EMT_OFF_BANK       12'h008
`define EMT_OFF_STATUS     12'h00C
`define EMT_OFF_RDATA      12'h010
// Reset values
`define EMT_CONFIG_RST     5'h00
`define EMT_TIMING_RST     8'hFF
`define EMT_BANK_RST       8'h00
// Timing field positions
`define EMT_SETUP_HI       7
`define EMT_SETUP_LO       6
`define EMT_WIDTH_HI       5
`define EMT_WIDTH_LO       2
`define EMT_HOLD_HI        1
`define EMT_HOLD_LO        0
// Config field positions: mode in [4:2], latch width in [1:0]
`define EMT_MODE_HI        4
`define EMT_MODE_LO        2
`define EMT_ALE_HI         1
`define EMT_ALE_LO         0
// Fixed overhead clocks of an off-chip move
`define EMT_OVERHEAD       3'd4
`endif

/* File: emt_counter.v */
// Purpose: Down counter used for every timed phase of a bus access
// Assumes: Load has priority over counting
// Notes:   done is high while the count is zero
module emt_counter (
   input  wire       clk,
   input  wire       resetn,
   input  wire       load,
   input  wire [4:0] value,
   output wire       done
);
   reg [4:0] count;

   // Reload on phase entry, otherwise count toward zero
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= 5'h00;
      end else if (load) begin
         count <= value;
      end else if (count != 5'h00) begin
         count <= count - 5'h01;
      end
   end

   assign done = (count == 5'h00);
endmodule

/* File: emt_bus_chk.sv */
// Purpose: Pin timing assertions for emt_bus
// Assumes: Config and timing are shadowed from APB writes
// Notes:   Setup length is checked in non-multiplexed modes only
`include "emt_regs.vh"
module emt_bus_chk (
   input logic        clk,
   input logic        resetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        busy,
   input logic [15:0] addr_oe,
   input logic        data_oe,
   input logic        ale,
   input logic        rd_n,
   input logic        wr_n,
   input logic        low_group_en,
   input logic        high_group_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tim;
   logic [4:0] cfg;
   logic [4:0] sl;
   logic [4:0] ac;
   logic [4:0] su;
   wire        stb = rd_n & wr_n;
   wire        wen = psel & penable & pready & pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Shadows and phase counters; a write lands on the same edge as in the block
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tim <= `EMT_TIMING_RST;
         cfg <= `EMT_CONFIG_RST;
         sl  <= 5'h0;
         ac  <= 5'h0;
         su  <= 5'h0;
      end else begin
         if (wen && paddr == `EMT_OFF_TIMING) tim <= pwdata[7:0];
         if (wen && paddr == `EMT_OFF_CONFIG) cfg <= pwdata[4:0];
         sl <= stb ? 5'h0 : sl + 5'h1;
         ac <= ale ? ac + 5'h1 : 5'h0;
         su <= (busy && stb) ? su + 5'h1 : 5'h0;
      end
   end
   a_strobe_width: assert property ($rose(stb) |-> sl == {1'b0, tim[5:2]} + 5'h1)
      else $error("strobe width wrong");
   a_ale_width: assert property ($fell(ale) |-> ac == {3'h0, cfg[1:0]} + 5'h1)
      else $error("latch pulse width wrong");
   a_setup_len: assert property ($fell(stb) && cfg[4] |-> su == {3'h0, tim[7:6]} + 5'h1)
      else $error("setup length wrong");
   a_no_ale_nonmux: assert property (cfg[4] |-> !ale)
      else $error("latch pulse in non-multiplexed mode");
   a_pins_idle: assert property (!busy |-> addr_oe == 16'h0 && !data_oe && stb && !ale)
      else $error("bus pins active while idle");
   a_one_strobe: assert property (rd_n || wr_n)
      else $error("both strobes low");
   a_wr_data: assert property (!wr_n |-> data_oe)
      else $error("write strobe without data");
   a_rd_release: assert property (!rd_n |-> !data_oe)
      else $error("data driven during read");
   a_group_one: assert property (busy |-> low_group_en != high_group_en)
      else $error("port group select wrong");
   c_mux: cover property ($fell(ale));
   c_write: cover property ($rose(wr_n));
   c_read: cover property ($rose(rd_n) && cfg[4]);
endmodule
bind emt_bus emt_bus_chk i_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .busy, .addr_oe, .data_oe, .ale, .rd_n, .wr_n, .low_group_en, .high_group_en);

/* File: emt_mem.sv */
// Purpose: Asynchronous byte memory on the external bus
// Assumes: Address latched at the pulse when one is seen, else at strobe
// Notes:   Slow mode leaves the first read cycle with junk
module emt_mem (
   input  logic        clk,
   input  logic [15:0] addr_out,
   input  logic [15:0] addr_oe,
   input  logic [7:0]  data_out,
   input  logic        ale,
   input  logic        rd_n,
   input  logic        wr_n,
   input  logic        slow,
   output logic [7:0]  data_in,
   output logic [15:0] la,
   output logic [15:0] loe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic [7:0] q = 8'h0;
   logic       rdl = 1'b0;
   logic       stl = 1'b0;
   logic       sawale = 1'b0;
   wire [15:0] ea = sawale ? la : addr_out;
   // Released bus shows the inverse of its last value, so nothing stale passes
   assign data_in = (!rd_n && (!slow || rdl)) ? mem[ea] : ~q;
   // Address capture and write store
   always_ff @(posedge clk) begin
      q <= data_in;
      rdl <= !rd_n;
      stl <= !(rd_n && wr_n);
      if (ale) begin
         la <= {addr_out[15:8], data_out};
         sawale <= 1'b1;
      end else if (!(rd_n && wr_n)) begin
         if (!sawale) la <= addr_out;
         loe <= addr_oe;
      end else if (stl) begin
         sawale <= 1'b0;
      end
      if (!wr_n) mem[ea] <= data_out;
   end
endmodule

/* File: test_emt_bus.sv */
// Purpose: Self-checking bench for emt_bus
// Assumes: APB master and move requests driven on rising edges
// Notes:   Each row writes then reads back one byte
`include "emt_regs.vh"
module test_emt_bus;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [4:0]  cfg;
      logic [7:0]  tim;
      logic        wide;
      logic        slow;
      logic        up;
      logic [15:0] a;
      logic [7:0]  d;
   } emt_row;
   localparam logic [7:0] BANK = 8'hA5;
   // Each bus-on mode code, with 010 and 110 used twice; reads need data two clocks before strobe end,
   // so fast rows use three strobe clocks or more and slow rows four
   emt_row rows [8] = '{
      '{5'h04, 8'h08, 1'b1, 1'b0, 1'b0, 16'h1234, 8'h5A},
      '{5'h09, 8'h4C, 1'b0, 1'b1, 1'b0, 16'h2345, 8'hC3},
      '{5'h0F, 8'hFF, 1'b0, 1'b0, 1'b1, 16'h3456, 8'h81},
      '{5'h14, 8'h09, 1'b1, 1'b0, 1'b1, 16'h4567, 8'h7E},
      '{5'h18, 8'h8F, 1'b0, 1'b1, 1'b0, 16'h5678, 8'h0F},
      '{5'h1C, 8'hC9, 1'b0, 1'b0, 1'b0, 16'h6789, 8'hF0},
      '{5'h18, 8'h3C, 1'b1, 1'b0, 1'b0, 16'h789A, 8'h33},
      '{5'h0A, 8'h08, 1'b1, 1'b0, 1'b1, 16'h89AB, 8'hCC}};
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req = 1'b0;
   logic        req_write = 1'b0, req_wide = 1'b0, upper_group = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] req_addr = 16'h0, addr_out, addr_oe, la, loe;
   logic [7:0]  req_wdata = 8'h0, rdata, data_out, data_in;
   logic        pready, pslverr, busy, done, data_oe, ale, rd_n, wr_n;
   logic        low_group_en, high_group_en;
   int          failures = 0;
   int          n_checks = 0;
   always #4 clk = ~clk;
   emt_bus i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .req, .req_write, .req_wide, .req_addr, .req_wdata, .upper_group,
      .busy, .done, .rdata, .addr_out, .addr_oe, .data_out, .data_oe, .data_in, .ale,
      .rd_n, .wr_n, .low_group_en, .high_group_en);
   emt_mem i_mem (.clk, .addr_out, .addr_oe, .data_out, .ale, .rd_n, .wr_n, .slow,
      .data_in, .la, .loe);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Access clocks: latch phases when multiplexed, then setup, strobe, hold, tail
   function automatic int tot(input logic [4:0] c, input logic [7:0] t);
      return (c[4] ? 0 : 2 * (c[1:0] + 1)) + t[7:6] + t[5:2] + t[1:0] + 4;
   endfunction
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) failures++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One move; counts busy clocks and waits for done with a bound
   task automatic mv(input logic w, input emt_row r, output int n, output logic [7:0] d);
      @(posedge clk);
      req <= 1'b1;
      req_write <= w;
      req_wide <= r.wide;
      req_addr <= r.a;
      req_wdata <= r.d;
      upper_group <= r.up;
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      for (int k = 0; k < 200; k++) begin
         @(posedge clk);
         if (busy === 1'b1) n++;
         if (n == 1 && busy === 1'b1) chk({high_group_en, low_group_en}, r.up ? 2 : 1);
         if (done === 1'b1) break;
      end
      d = rdata;
   endtask
   initial begin
      emt_row      r;
      logic [31:0] rd;
      logic        e;
      logic [7:0]  d8;
      logic [15:0] m;
      int          n;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      apb(0, `EMT_OFF_TIMING, 0, rd, e);
      chk(rd, `EMT_TIMING_RST);
      apb(1, `EMT_OFF_BANK, BANK, rd, e);
      apb(0, `EMT_OFF_BANK, 0, rd, e);
      chk(rd, BANK);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         apb(1, `EMT_OFF_CONFIG, r.cfg, rd, e);
         apb(1, `EMT_OFF_TIMING, r.tim, rd, e);
         slow <= r.slow;
         mv(1, r, n, d8);
         chk(n, tot(r.cfg, r.tim));
         mv(0, r, n, d8);
         chk(d8, r.d);
         chk(n, tot(r.cfg, r.tim));
         m = (r.wide || r.cfg[3:2] == 2'b10) ? 16'hFFFF : 16'h00FF;
         chk(la & m, (r.wide ? r.a : {BANK, r.a[7:0]}) & m);
         chk(loe[15:8], m[15:8]);
         $display("row %0d done", i);
      end
      apb(0, 12'hFFC, 0, rd, e);
      chk(e, 1);
      chk(rd, 0);
      $display("unmapped done");
      // Second reset while configured: timing back to longest, bus off
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      apb(0, `EMT_OFF_TIMING, 0, rd, e);
      chk(rd, `EMT_TIMING_RST);
      mv(0, rows[0], n, d8);
      chk(n, 0);
      $display("reset done");
      results;
   end
   // Watchdog at 5000 clocks, well beyond the expected few hundred clocks
   initial begin
      #40000;
      failures++;
      results;
   end
endmodule
